// File: rtl/strap_pkg.sv
// constants and types for the port 2 / PHY B soft-strap default loader
// assumes a 32-bit classic Wishbone register bus and 16-bit PHY registers
package strap_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_BASIC = 8'h00;
	localparam logic [7:0] OFS_ADVERT = 8'h04;
	localparam logic [7:0] OFS_MODES = 8'h08;
	localparam logic [7:0] OFS_FLOWCTL = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// phy_basic_control_reg fields
	localparam int BASIC_SPEED_LOW_BIT = 13;
	localparam int BASIC_AUTONEG_BIT = 12;
	localparam int BASIC_DUPLEX_BIT = 8;
	localparam logic [15:0] BASIC_BASE = 16'h0000;

	// phy_autoneg_advert_reg fields
	localparam int ADV_ASYM_PAUSE_BIT = 11;
	localparam int ADV_SYM_PAUSE_BIT = 10;
	localparam int ADV_10FD_BIT = 6;
	localparam int ADV_10HD_BIT = 5;
	// selector field and 100 Mb/s abilities always advertised
	localparam logic [15:0] ADV_BASE = 16'h0181;

	// phy_special_modes_reg operating mode field
	localparam int MODES_MODE_LSB = 5;
	localparam logic [15:0] MODES_BASE = 16'h0000;
	localparam logic [2:0] MODE_10HD = 3'h0;
	localparam logic [2:0] MODE_10FD = 3'h1;
	localparam logic [2:0] MODE_100HD = 3'h2;
	localparam logic [2:0] MODE_100FD = 3'h3;
	localparam logic [2:0] MODE_AUTONEG = 3'h7;

	// port 2 manual flow control register fields
	localparam int FC_BACKPRESSURE_BIT = 0;
	localparam int FC_TX_FLOWCTL_BIT = 1;
	localparam int FC_RX_FLOWCTL_BIT = 2;
	localparam int FC_MANUAL_BIT = 3;

	// status register fields
	localparam int STAT_READY_BIT = 8;
	localparam int STAT_FIBER_BIT = 7;
	localparam int STAT_EEPROM_BIT = 6;

	// cycles from reset release until pins are sampled (synchroniser depth + 1)
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;

	typedef struct packed {
		logic autoneg;
		logic speed;
		logic duplex;
		logic backpressure;
		logic fdx_flowctl;
		logic manual_flowctl;
	} strap_t;

	localparam strap_t STRAP_RESET = '{autoneg: 1'b1, speed: 1'b1, duplex: 1'b1,
		backpressure: 1'b1, fdx_flowctl: 1'b1, manual_flowctl: 1'b0};

	typedef struct packed {
		logic [15:0] basic;
		logic [15:0] advert;
		logic [15:0] modes;
		logic [7:0] flowctl;
	} defaults_t;

endpackage : strap_pkg

// File: rtl/strap_sync.sv
// two-flop synchroniser bank for asynchronous strap pins
// assumes the pins are quasi-static; bits are not coherent with each other
`timescale 1ns/1ps
module strap_sync #(
	parameter int WIDTH = 7
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : strap_sync

// File: rtl/port2_phy_soft_strap_defaults.sv
// port 2 switch port and PHY B register defaults driven by soft straps
// assumes strap pins are asynchronous, loader inputs on CLK_IN, classic Wishbone slave
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

// How it works
// [R1] autoneg strap sets autoneg enable default
// [R2] autoneg strap shapes speed, duplex, 10M, mode
// [R3] speed strap shapes speed, 10M adverts, mode
// [R4] duplex strap shapes duplex, 10FD, mode
// [R5] fiber mode ignores autoneg, speed straps, clears 10M and pause adverts
// [R6] backpressure strap sets port backpressure default
// [R7] fdx flowctl strap sets tx/rx enables
// [R8] fdx flowctl strap sets asymmetric pause advert
// [R9] manual strap sets manual flowctl select
// [R10] manual strap sets both pause adverts
// [R11] loader replaces soft straps, never fiber strap
// [R12] defaults load at reset, writes override after
module port2_phy_soft_strap_defaults (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic AUTONEG_STRAP_IN,
	input wire logic SPEED_STRAP_IN,
	input wire logic DUPLEX_STRAP_IN,
	input wire logic PORT2_BACKPRESSURE_DEFAULT_IN,
	input wire logic PORT2_FDX_FLOWCTL_DEFAULT_IN,
	input wire logic PORT2_MANUAL_FLOWCTL_DEFAULT_IN,
	input wire logic FIBER_MODE_STRAP_IN,
	input wire logic EE_LOAD_IN,
	input wire strap_pkg::strap_t EE_STRAPS_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	output logic AUTONEG_ENABLE_OUT,
	output logic SPEED_SELECT_LOW_OUT,
	output logic DUPLEX_OUT,
	output logic [15:0] ADVERT_OUT,
	output logic [2:0] PHY_MODE_OUT,
	output logic PORT2_BACKPRESSURE_ENABLE_OUT,
	output logic PORT2_TX_FLOWCTL_ENABLE_OUT,
	output logic PORT2_RX_FLOWCTL_ENABLE_OUT,
	output logic PORT2_MANUAL_FLOWCTL_OUT,
	output logic FIBER_MODE_OUT,
	output logic DEFAULTS_READY_OUT
);

	// defaults of every affected bit, for one strap set and fiber flag
	function automatic strap_pkg::defaults_t derive(input strap_pkg::strap_t s,
		input logic fiber);
		strap_pkg::defaults_t d;
		logic an;
		logic spd;
		logic ten;
		d.basic = strap_pkg::BASIC_BASE;
		d.advert = strap_pkg::ADV_BASE;
		d.modes = strap_pkg::MODES_BASE;
		d.flowctl = 8'h00;
		// fiber forces fixed 100 Mb/s, no negotiation
		an = fiber ? 1'b0 : s.autoneg; // [R5]
		spd = fiber ? 1'b1 : s.speed; // [R5]
		ten = an | ~spd;
		d.basic[strap_pkg::BASIC_AUTONEG_BIT] = an; // [R1]
		d.basic[strap_pkg::BASIC_SPEED_LOW_BIT] = an | spd; // [R2] [R3]
		d.basic[strap_pkg::BASIC_DUPLEX_BIT] = an | s.duplex; // [R2] [R4]
		if (!fiber) begin
			d.advert[strap_pkg::ADV_10HD_BIT] = ten; // [R2] [R3]
			d.advert[strap_pkg::ADV_10FD_BIT] = ten & s.duplex; // [R2] [R3] [R4]
			d.advert[strap_pkg::ADV_SYM_PAUSE_BIT] = ~s.manual_flowctl; // [R10]
			// manual select withdraws both pause abilities
			d.advert[strap_pkg::ADV_ASYM_PAUSE_BIT] =
				s.fdx_flowctl & ~s.manual_flowctl; // [R8] [R10]
		end
		if (fiber) begin
			d.modes[strap_pkg::MODES_MODE_LSB +: 3] =
				s.duplex ? strap_pkg::MODE_100FD : strap_pkg::MODE_100HD; // [R4] [R5]
		end else if (an) begin
			d.modes[strap_pkg::MODES_MODE_LSB +: 3] = strap_pkg::MODE_AUTONEG; // [R2]
		end else begin
			case ({spd, s.duplex})
				2'b00: d.modes[strap_pkg::MODES_MODE_LSB +: 3] = strap_pkg::MODE_10HD;
				2'b01: d.modes[strap_pkg::MODES_MODE_LSB +: 3] = strap_pkg::MODE_10FD;
				2'b10: d.modes[strap_pkg::MODES_MODE_LSB +: 3] = strap_pkg::MODE_100HD;
				default: d.modes[strap_pkg::MODES_MODE_LSB +: 3] = strap_pkg::MODE_100FD;
			endcase // [R3] [R4]
		end
		// port flow control is a switch setting, fiber does not touch it
		d.flowctl[strap_pkg::FC_BACKPRESSURE_BIT] = s.backpressure; // [R6]
		d.flowctl[strap_pkg::FC_TX_FLOWCTL_BIT] = s.fdx_flowctl; // [R7]
		d.flowctl[strap_pkg::FC_RX_FLOWCTL_BIT] = s.fdx_flowctl; // [R7]
		d.flowctl[strap_pkg::FC_MANUAL_BIT] = s.manual_flowctl; // [R9]
		return d;
	endfunction : derive

	// byte-lane merge for a 16-bit register in the low half-word
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wdat,
		input logic [1:0] sel);
		logic [15:0] r;
		// unused byte lanes keep their old value
		r = old;
		if (sel[0]) begin
			r[7:0] = wdat[7:0];
		end
		if (sel[1]) begin
			r[15:8] = wdat[15:8];
		end
		return r;
	endfunction : merge16

	// async reset values: default strap levels, copper mode
	localparam strap_pkg::defaults_t RESET_DEFAULTS = derive(strap_pkg::STRAP_RESET, 1'b0);

	logic [6:0] pins_sync;
	strap_pkg::strap_t pin_straps;
	logic fiber_pin;

	// one bank for all seven pins, fiber rides in bit 0
	strap_sync #(
		.WIDTH(7)
	) u_strap_sync (
		.clk_in(CLK_IN),
		.nrst_in(NRST_IN),
		.async_in({AUTONEG_STRAP_IN, SPEED_STRAP_IN, DUPLEX_STRAP_IN,
			PORT2_BACKPRESSURE_DEFAULT_IN, PORT2_FDX_FLOWCTL_DEFAULT_IN,
			PORT2_MANUAL_FLOWCTL_DEFAULT_IN, FIBER_MODE_STRAP_IN}),
		.sync_out(pins_sync)
	);

	assign pin_straps = strap_pkg::strap_t'(pins_sync[6:1]);
	assign fiber_pin = pins_sync[0];

	// strap capture after reset release
	// pins are sampled once per reset; later pin changes are ignored
	// until the next reset, so slow straps must settle before capture
	logic [1:0] settle_q;
	logic ready_q;
	logic capture;
	logic ee_apply;
	logic apply;
	strap_pkg::strap_t straps_q;
	strap_pkg::strap_t apply_straps;
	logic fiber_q;
	logic fiber_next;
	logic eeprom_loaded_q;
	strap_pkg::defaults_t new_defaults;

	assign capture = !ready_q && (settle_q == strap_pkg::SETTLE_CYCLES);
	// loader values only after pins are in, so it always has the last word
	assign ee_apply = ready_q && EE_LOAD_IN; // [R11]
	assign apply = capture | ee_apply; // [R12]
	assign apply_straps = ee_apply ? EE_STRAPS_IN : pin_straps; // [R11]
	// fiber is a hard strap: pins only, loader cannot change it
	assign fiber_next = capture ? fiber_pin : fiber_q; // [R11]
	assign new_defaults = derive(apply_straps, fiber_next);

	// settle counter stops at its end value, ready_q then freezes it
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			settle_q <= 2'h0;
		end else if (!ready_q && settle_q != strap_pkg::SETTLE_CYCLES) begin
			settle_q <= settle_q + 2'h1;
		end
	end

	// ready is sticky until reset; loader pulses before it are dropped
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ready_q <= 1'b0;
		end else if (capture) begin
			ready_q <= 1'b1;
		end
	end

	// effective straps kept for the status word; fiber_q also drives FIBER_MODE_OUT
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			straps_q <= strap_pkg::STRAP_RESET;
			fiber_q <= 1'b0;
		end else if (apply) begin
			straps_q <= apply_straps; // [R11]
			fiber_q <= fiber_next;
		end
	end

	// sticky, so software can tell loader values from pin values
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			eeprom_loaded_q <= 1'b0;
		end else if (ee_apply) begin
			eeprom_loaded_q <= 1'b1;
		end
	end

	// wishbone slave, one wait state, ack for one cycle
	logic ack_q;
	logic [31:0] rdata_q;
	logic access;
	logic wr;
	logic [31:0] rdata_d;

	assign access = WB_CYC_IN && WB_STB_IN && !ack_q;
	assign wr = access && WB_WE_IN;

	logic [15:0] basic_q;
	logic [15:0] advert_q;
	logic [15:0] modes_q;
	logic [7:0] flowctl_q;

	// strap load wins over a write landing in the same cycle
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			basic_q <= RESET_DEFAULTS.basic; // [R12]
		end else if (apply) begin
			basic_q <= new_defaults.basic; // [R1] [R2] [R3] [R4] [R5]
		end else if (wr && WB_ADR_IN == strap_pkg::OFS_BASIC) begin
			basic_q <= merge16(basic_q, WB_DAT_IN[15:0], WB_SEL_IN[1:0]); // [R12]
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			advert_q <= RESET_DEFAULTS.advert; // [R12]
		end else if (apply) begin
			advert_q <= new_defaults.advert; // [R2] [R3] [R4] [R8] [R10]
		end else if (wr && WB_ADR_IN == strap_pkg::OFS_ADVERT) begin
			advert_q <= merge16(advert_q, WB_DAT_IN[15:0], WB_SEL_IN[1:0]); // [R12]
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			modes_q <= RESET_DEFAULTS.modes; // [R12]
		end else if (apply) begin
			modes_q <= new_defaults.modes; // [R2] [R3] [R4]
		end else if (wr && WB_ADR_IN == strap_pkg::OFS_MODES) begin
			modes_q <= merge16(modes_q, WB_DAT_IN[15:0], WB_SEL_IN[1:0]); // [R12]
		end
	end

	// only the four defined bits are writable, the rest read 0
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			flowctl_q <= RESET_DEFAULTS.flowctl; // [R12]
		end else if (apply) begin
			flowctl_q <= new_defaults.flowctl; // [R6] [R7] [R9]
		end else if (wr && WB_ADR_IN == strap_pkg::OFS_FLOWCTL && WB_SEL_IN[0]) begin
			flowctl_q <= {4'h0, WB_DAT_IN[3:0]}; // [R12]
		end
	end

	// status is read-only: writes to it are acked and dropped
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (WB_ADR_IN)
			strap_pkg::OFS_BASIC: rdata_d = {16'h0000, basic_q};
			strap_pkg::OFS_ADVERT: rdata_d = {16'h0000, advert_q};
			strap_pkg::OFS_MODES: rdata_d = {16'h0000, modes_q};
			strap_pkg::OFS_FLOWCTL: rdata_d = {24'h00_0000, flowctl_q};
			strap_pkg::OFS_STATUS: begin
				rdata_d[5:0] = straps_q;
				rdata_d[strap_pkg::STAT_EEPROM_BIT] = eeprom_loaded_q;
				rdata_d[strap_pkg::STAT_FIBER_BIT] = fiber_q;
				rdata_d[strap_pkg::STAT_READY_BIT] = ready_q;
			end
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// ack_q masks access, so a held strobe is not taken twice
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= access;
		end
	end

	// read data sampled with the request, zero for writes and idle cycles
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rdata_q <= 32'h0000_0000;
		end else if (access && !WB_WE_IN) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign WB_ACK_OUT = ack_q;
	assign WB_DAT_OUT = rdata_q;

	// outputs are plain register bits, no extra latency to the phy
	assign AUTONEG_ENABLE_OUT = basic_q[strap_pkg::BASIC_AUTONEG_BIT];
	assign SPEED_SELECT_LOW_OUT = basic_q[strap_pkg::BASIC_SPEED_LOW_BIT];
	assign DUPLEX_OUT = basic_q[strap_pkg::BASIC_DUPLEX_BIT];
	assign ADVERT_OUT = advert_q;
	assign PHY_MODE_OUT = modes_q[strap_pkg::MODES_MODE_LSB +: 3];
	assign PORT2_BACKPRESSURE_ENABLE_OUT = flowctl_q[strap_pkg::FC_BACKPRESSURE_BIT];
	assign PORT2_TX_FLOWCTL_ENABLE_OUT = flowctl_q[strap_pkg::FC_TX_FLOWCTL_BIT];
	assign PORT2_RX_FLOWCTL_ENABLE_OUT = flowctl_q[strap_pkg::FC_RX_FLOWCTL_BIT];
	assign PORT2_MANUAL_FLOWCTL_OUT = flowctl_q[strap_pkg::FC_MANUAL_BIT];
	assign FIBER_MODE_OUT = fiber_q;
	assign DEFAULTS_READY_OUT = ready_q;

endmodule : port2_phy_soft_strap_defaults

// File: tb/strap_source_model.sv
// far-side model: strap pins and the configuration loader
// assumes the bench calls set_pins and load between clock edges
`timescale 1ns/1ps
module strap_source_model (
	input wire logic clk_in,
	output strap_pkg::strap_t pins_out,
	output logic fiber_out,
	output logic ee_load_out,
	output strap_pkg::strap_t ee_straps_out
);
	initial begin
		pins_out = strap_pkg::STRAP_RESET;
		fiber_out = 1'b0;
		ee_load_out = 1'b0;
		ee_straps_out = ~strap_pkg::STRAP_RESET;
	end
	// pins are quasi-static: change them only well before capture
	task automatic set_pins(input strap_pkg::strap_t v, input logic f);
		@(posedge clk_in);
		pins_out <= v;
		fiber_out <= f;
	endtask : set_pins
	// image is garbage outside the strobe so a late sample shows up
	task automatic load(input strap_pkg::strap_t v);
		@(posedge clk_in);
		ee_load_out <= 1'b1;
		ee_straps_out <= v;
		@(posedge clk_in);
		ee_load_out <= 1'b0;
		ee_straps_out <= ~v;
	endtask : load
endmodule : strap_source_model

// File: tb/port2_phy_soft_strap_defaults_checker.sv
// concurrent checks on the strap default loader ports
// assumes binding into every instance of the loader
`timescale 1ns/1ps
module port2_phy_soft_strap_defaults_checker (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic EE_LOAD_IN,
	input wire strap_pkg::strap_t EE_STRAPS_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	input wire logic AUTONEG_ENABLE_OUT,
	input wire logic [15:0] ADVERT_OUT,
	input wire logic [2:0] PHY_MODE_OUT,
	input wire logic PORT2_BACKPRESSURE_ENABLE_OUT,
	input wire logic PORT2_TX_FLOWCTL_ENABLE_OUT,
	input wire logic PORT2_RX_FLOWCTL_ENABLE_OUT,
	input wire logic PORT2_MANUAL_FLOWCTL_OUT,
	input wire logic FIBER_MODE_OUT,
	input wire logic DEFAULTS_READY_OUT
);
	strap_pkg::strap_t ee_q;
	logic ld;
	assign ld = EE_LOAD_IN && DEFAULTS_READY_OUT;
	always_ff @(posedge CLK_IN) begin
		if (EE_LOAD_IN) begin
			ee_q <= EE_STRAPS_IN;
		end
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack held too long");
	a_ack_after_req: assert property (
		WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("request not acked");
	a_data_idle_zero: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
		else $error("read data outside ack");
	a_ready_sticks: assert property (DEFAULTS_READY_OUT |=> DEFAULTS_READY_OUT)
		else $error("ready dropped");
	a_fiber_fixed: assert property (DEFAULTS_READY_OUT |=> $stable(FIBER_MODE_OUT))
		else $error("fiber changed after capture");
	a_load_autoneg: assert property (
		ld |=> AUTONEG_ENABLE_OUT == (ee_q.autoneg && !FIBER_MODE_OUT))
		else $error("autoneg not loaded");
	a_load_mode: assert property (
		ld |=> PHY_MODE_OUT == ((ee_q.autoneg && !FIBER_MODE_OUT) ? 3'h7
		: {1'b0, ee_q.speed | FIBER_MODE_OUT, ee_q.duplex}))
		else $error("mode not loaded");
	a_load_port: assert property (
		ld |=> {PORT2_MANUAL_FLOWCTL_OUT, PORT2_RX_FLOWCTL_ENABLE_OUT,
		PORT2_TX_FLOWCTL_ENABLE_OUT, PORT2_BACKPRESSURE_ENABLE_OUT} == {ee_q.manual_flowctl,
		ee_q.fdx_flowctl, ee_q.fdx_flowctl, ee_q.backpressure})
		else $error("port bits not loaded");
	a_load_pause: assert property (
		ld |=> ADVERT_OUT[11:10] == (FIBER_MODE_OUT ? 2'h0
		: {ee_q.fdx_flowctl & ~ee_q.manual_flowctl, ~ee_q.manual_flowctl}))
		else $error("pause adverts not loaded");
	c_ready: cover property ($rose(DEFAULTS_READY_OUT));
	c_fiber_load: cover property (ld && FIBER_MODE_OUT);
	c_read_data: cover property (WB_ACK_OUT && WB_DAT_OUT != 32'h0);
endmodule : port2_phy_soft_strap_defaults_checker
bind port2_phy_soft_strap_defaults port2_phy_soft_strap_defaults_checker chk_u (.*);

// File: tb/tb_port2_phy_soft_strap_defaults.sv
// self-checking bench for the port 2 / PHY B strap default loader
// assumes strap_source_model drives pins and loader, bench owns the bus
`timescale 1ns/1ps
module tb_port2_phy_soft_strap_defaults;
	logic CLK_IN = 1'b0;
	logic NRST_IN = 1'b0;
	logic WB_CYC_IN = 1'b0;
	logic WB_STB_IN = 1'b0;
	logic WB_WE_IN = 1'b0;
	logic [7:0] WB_ADR_IN = 8'h00;
	logic [3:0] WB_SEL_IN = 4'h0;
	logic [31:0] WB_DAT_IN = 32'h0;
	logic [31:0] WB_DAT_OUT;
	logic WB_ACK_OUT, AUTONEG_ENABLE_OUT, SPEED_SELECT_LOW_OUT, DUPLEX_OUT, FIBER_MODE_OUT;
	logic DEFAULTS_READY_OUT, PORT2_BACKPRESSURE_ENABLE_OUT, PORT2_TX_FLOWCTL_ENABLE_OUT;
	logic PORT2_RX_FLOWCTL_ENABLE_OUT, PORT2_MANUAL_FLOWCTL_OUT, EE_LOAD_IN, fiber;
	logic [15:0] ADVERT_OUT;
	logic [2:0] PHY_MODE_OUT;
	strap_pkg::strap_t EE_STRAPS_IN, pins;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [3:0] sel = 4'hF;
	logic [5:0] vals [7] = '{6'h00, 6'h09, 6'h12, 6'h1B, 6'h26, 6'h3F, 6'h35};
	strap_source_model src_u (.clk_in(CLK_IN), .pins_out(pins), .fiber_out(fiber),
		.ee_load_out(EE_LOAD_IN), .ee_straps_out(EE_STRAPS_IN));
	port2_phy_soft_strap_defaults dut_u (.AUTONEG_STRAP_IN(pins.autoneg),
		.SPEED_STRAP_IN(pins.speed), .DUPLEX_STRAP_IN(pins.duplex),
		.PORT2_BACKPRESSURE_DEFAULT_IN(pins.backpressure),
		.PORT2_FDX_FLOWCTL_DEFAULT_IN(pins.fdx_flowctl),
		.PORT2_MANUAL_FLOWCTL_DEFAULT_IN(pins.manual_flowctl),
		.FIBER_MODE_STRAP_IN(fiber), .*);
	initial begin
		forever #5 CLK_IN = ~CLK_IN;
	end
	// whole run needs well under a thousand cycles
	always @(posedge CLK_IN) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge CLK_IN);
		WB_CYC_IN <= 1'b1;
		WB_STB_IN <= 1'b1;
		WB_WE_IN <= we;
		WB_ADR_IN <= a;
		WB_SEL_IN <= sel;
		WB_DAT_IN <= wd;
		do @(posedge CLK_IN); while (WB_ACK_OUT !== 1'b1);
		rd = WB_DAT_OUT;
		WB_CYC_IN <= 1'b0;
		WB_STB_IN <= 1'b0;
	endtask : wb
	function automatic strap_pkg::defaults_t expect_regs(strap_pkg::strap_t s, logic f);
		logic an, spd, m10;
		strap_pkg::defaults_t d;
		an = s.autoneg & ~f;
		spd = s.speed | f;
		m10 = an | ~spd;
		d.basic = {2'h0, an | spd, an, 3'h0, an | s.duplex, 8'h00};
		d.advert = strap_pkg::ADV_BASE | {4'h0, ~f & s.fdx_flowctl & ~s.manual_flowctl,
			~f & ~s.manual_flowctl, 3'h0, m10 & s.duplex, m10, 5'h00};
		d.modes = {8'h00, an ? 3'h7 : {1'b0, spd, s.duplex}, 5'h00};
		d.flowctl = {4'h0, s.manual_flowctl, s.fdx_flowctl, s.fdx_flowctl, s.backpressure};
		return d;
	endfunction : expect_regs
	task automatic chk_all(input strap_pkg::strap_t s, input logic f, input logic ee);
		strap_pkg::defaults_t d;
		logic [31:0] r;
		d = expect_regs(s, f);
		wb(1'b0, strap_pkg::OFS_BASIC, 32'h0, r);
		check(r, {16'h0, d.basic});
		wb(1'b0, strap_pkg::OFS_ADVERT, 32'h0, r);
		check(r, {16'h0, d.advert});
		wb(1'b0, strap_pkg::OFS_MODES, 32'h0, r);
		check(r, {16'h0, d.modes});
		wb(1'b0, strap_pkg::OFS_FLOWCTL, 32'h0, r);
		check(r, {24'h0, d.flowctl});
		wb(1'b0, strap_pkg::OFS_STATUS, 32'h0, r);
		check(r, {23'h0, 1'b1, f, ee, s});
		check({5'h0, AUTONEG_ENABLE_OUT, SPEED_SELECT_LOW_OUT, DUPLEX_OUT, FIBER_MODE_OUT,
			PHY_MODE_OUT, PORT2_MANUAL_FLOWCTL_OUT, PORT2_RX_FLOWCTL_ENABLE_OUT,
			PORT2_TX_FLOWCTL_ENABLE_OUT, PORT2_BACKPRESSURE_ENABLE_OUT, ADVERT_OUT},
			{5'h0, d.basic[12], d.basic[13], d.basic[8], f,
			d.modes[7:5], d.flowctl[3:0], d.advert});
	endtask : chk_all
	initial begin
		logic [31:0] r;
		strap_pkg::defaults_t d;
		src_u.set_pins(6'h12, 1'b0);
		repeat (2) @(posedge CLK_IN);
		check({9'h0, AUTONEG_ENABLE_OUT, SPEED_SELECT_LOW_OUT, DUPLEX_OUT, PORT2_MANUAL_FLOWCTL_OUT,
			PORT2_RX_FLOWCTL_ENABLE_OUT, PORT2_TX_FLOWCTL_ENABLE_OUT, PORT2_BACKPRESSURE_ENABLE_OUT,
			ADVERT_OUT}, {9'h0, 3'h7, 4'h7, 16'h0DE1});
		NRST_IN <= 1'b1;
		while (DEFAULTS_READY_OUT !== 1'b1) @(posedge CLK_IN);
		chk_all(6'h12, 1'b0, 1'b0);
		foreach (vals[i]) begin
			src_u.load(vals[i]);
			chk_all(vals[i], 1'b0, 1'b1);
		end
		wb(1'b1, strap_pkg::OFS_BASIC, 32'h0, r);
		wb(1'b0, strap_pkg::OFS_BASIC, 32'h0, r);
		check(r, 32'h0);
		// high byte lane only: the low byte must keep its strap default
		d = expect_regs(vals[6], 1'b0);
		sel = 4'h2;
		wb(1'b1, strap_pkg::OFS_ADVERT, 32'h0000_FFFF, r);
		sel = 4'hF;
		wb(1'b0, strap_pkg::OFS_ADVERT, 32'h0, r);
		check(r, {16'h0000, 8'hFF, d.advert[7:0]});
		wb(1'b0, 8'h14, 32'h0, r);
		check(r, 32'h0);
		src_u.load(6'h26);
		chk_all(6'h26, 1'b0, 1'b1);
		src_u.set_pins(6'h3F, 1'b1);
		NRST_IN <= 1'b0;
		repeat (3) @(posedge CLK_IN);
		NRST_IN <= 1'b1;
		while (DEFAULTS_READY_OUT !== 1'b1) @(posedge CLK_IN);
		chk_all(6'h3F, 1'b1, 1'b0);
		src_u.load(6'h09);
		chk_all(6'h09, 1'b1, 1'b1);
		stop_test();
	end
endmodule : tb_port2_phy_soft_strap_defaults
